// File: src/dacc_pkg.sv
// Constants, register map and field layout of the two-channel address/count block.
// Assumes a plain register port with 32-bit data and a single system clock.

package dacc_pkg;

   localparam int unsigned ADDR_W   = 8;
   localparam int unsigned DATA_W   = 32;
   localparam int unsigned CNT_W    = 24;
   localparam int unsigned CTRL_W   = 16;

   // Register offsets; channel 1 sits one channel stride above channel 0
   localparam logic [7:0] OFS_SRC    = 8'h00;
   localparam logic [7:0] OFS_DST    = 8'h04;
   localparam logic [7:0] OFS_CNT    = 8'h08;
   localparam logic [7:0] OFS_CTRL   = 8'h0c;
   localparam logic [7:0] OFS_CH_STR = 8'h10;
   localparam logic [7:0] CH_MASK    = 8'h0f;

   // Control field positions
   localparam int unsigned DST_MODE_HI = 15;
   localparam int unsigned DST_MODE_LO = 14;
   localparam int unsigned SRC_MODE_HI = 13;
   localparam int unsigned SRC_MODE_LO = 12;
   localparam int unsigned SIZE_HI     = 11;
   localparam int unsigned SIZE_LO     = 10;
   localparam int unsigned ACK_DIR_BIT = 8;
   localparam int unsigned ADDR_MODE_BIT = 3;
   localparam int unsigned TEND_BIT    = 1;
   localparam int unsigned ENABLE_BIT  = 0;

   localparam logic [15:0] CTRL_RST   = 16'h0000;
   localparam logic [23:0] CNT_ONE    = 24'h000001;
   localparam logic [2:0]  LW_STEPS   = 3'h4;

   typedef enum logic [1:0] {
      DACC_STEP_FIXED = 2'b00,
      DACC_STEP_INC   = 2'b01,
      DACC_STEP_DEC   = 2'b10,
      DACC_STEP_RSVD  = 2'b11
   } dacc_step_t;

   typedef enum logic [1:0] {
      DACC_SZ_BYTE = 2'b00,
      DACC_SZ_WORD = 2'b01,
      DACC_SZ_LONG = 2'b10,
      DACC_SZ_16B  = 2'b11
   } dacc_size_t;

   localparam logic [31:0] STEP_BYTE = 32'h00000001;
   localparam logic [31:0] STEP_WORD = 32'h00000002;
   localparam logic [31:0] STEP_LONG = 32'h00000004;
   localparam logic [31:0] STEP_16B  = 32'h00000010;

   typedef enum logic [1:0] {
      DACC_ST_IDLE = 2'b00,
      DACC_ST_RUN  = 2'b01,
      DACC_ST_BURST = 2'b10
   } dacc_state_t;

endpackage

// File: src/dacc_channel_regs.sv
// Two-channel address, count and control registers with per-unit update logic.
// Assumes an outside sequencer that pulses unit_done once per finished unit
// step of an enabled channel, and a standby_entry pulse from power control.
`timescale 1ns/1ps

module dacc_channel_regs
   import dacc_pkg::*;
#(
   parameter int unsigned NUM_CH = 2
) (
   input  wire logic                        ref_clk,
   input  wire logic                        arst_n,
   input  wire logic                        standby_entry,
   input  wire logic [dacc_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [dacc_pkg::DATA_W-1:0] reg_wdata,
   input  wire logic                        reg_wr,
   input  wire logic                        reg_rd,
   output logic      [dacc_pkg::DATA_W-1:0] reg_rdata,
   input  wire logic [NUM_CH-1:0]           unit_done,
   output logic      [NUM_CH-1:0]           ch_enable,
   output logic      [NUM_CH-1:0]           ch_active,
   output logic      [NUM_CH-1:0]           ch_single_addr,
   output logic      [NUM_CH-1:0]           ch_dev_to_mem,
   output logic      [NUM_CH-1:0]           ch_src_used,
   output logic      [NUM_CH-1:0]           ch_dst_used,
   output logic      [NUM_CH*32-1:0]        ch_src_addr,
   output logic      [NUM_CH*32-1:0]        ch_dst_addr,
   output logic      [NUM_CH-1:0]           ch_lw_phase_last
);
   import dacc_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [NUM_CH-1:0][31:0]       src;
      logic [NUM_CH-1:0][31:0]       dst;
      logic [NUM_CH-1:0][CNT_W-1:0]  cnt;
      logic [NUM_CH-1:0][CTRL_W-1:0] ctrl;
      logic [NUM_CH-1:0][1:0]        lw_idx;
      logic [DATA_W-1:0]             rdata;
   } dacc_state_s_t;

   dacc_state_s_t state_reg;
   dacc_state_s_t state_next;

   // ----------------------------------------------------------------
   // Step size for one unit
   // ----------------------------------------------------------------
   function automatic logic [31:0] unit_step(input logic [1:0] sz);
      logic [31:0] s;
      s = STEP_BYTE;
      case (sz)
         DACC_SZ_BYTE: s = STEP_BYTE;
         DACC_SZ_WORD: s = STEP_WORD;
         DACC_SZ_LONG: s = STEP_LONG;
         DACC_SZ_16B:  s = STEP_16B;
         default:      s = STEP_BYTE;
      endcase
      return s;
   endfunction

   // Reserved step code behaves as fixed; software must not use it
   function automatic logic [31:0] stepped(input logic [31:0] a, input logic [1:0] md,
                                           input logic [31:0] st);
      logic [31:0] r;
      r = a;
      case (md)
         DACC_STEP_INC:   r = a + st;
         DACC_STEP_DEC:   r = a - st;
         DACC_STEP_FIXED: r = a;
         default:         r = a;
      endcase
      return r;
   endfunction

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [7:0]  ch_base;
      logic [7:0]  reg_ofs;
      logic [1:0]  sz;
      logic [1:0]  dmode;
      logic [1:0]  smode;
      logic        single;
      logic        d2m;
      logic        lw_done;
      logic [31:0] st;
      state_next = state_reg;
      ch_base = 8'h00;
      reg_ofs = 8'h00;
      sz = 2'b00;
      dmode = 2'b00;
      smode = 2'b00;
      single = 1'b0;
      d2m = 1'b0;
      lw_done = 1'b0;
      st = 32'h00000000;
      state_next.rdata = '0;

      for (int c = 0; c < NUM_CH; c++) begin
         sz     = state_reg.ctrl[c][SIZE_HI:SIZE_LO];
         dmode  = state_reg.ctrl[c][DST_MODE_HI:DST_MODE_LO];
         smode  = state_reg.ctrl[c][SRC_MODE_HI:SRC_MODE_LO];
         single = state_reg.ctrl[c][ADDR_MODE_BIT];
         d2m    = state_reg.ctrl[c][ACK_DIR_BIT];
         st     = unit_step(sz);

         // Software access, taken first so a later unit step can still land
         ch_base = 8'(c) * OFS_CH_STR;
         reg_ofs = reg_addr - ch_base;
         if (reg_wr && reg_addr >= ch_base && reg_addr <= (ch_base | CH_MASK)) begin
            case (reg_ofs)
               OFS_SRC:  state_next.src[c] = reg_wdata;
               OFS_DST:  state_next.dst[c] = reg_wdata;
               OFS_CNT:  state_next.cnt[c] = reg_wdata[CNT_W-1:0];
               OFS_CTRL: begin
                  // Flag only clears; writing one keeps current value
                  state_next.ctrl[c] = reg_wdata[CTRL_W-1:0];
                  state_next.ctrl[c][TEND_BIT] = state_reg.ctrl[c][TEND_BIT]
                                                 & reg_wdata[TEND_BIT];
                  state_next.lw_idx[c] = 2'b00;
               end
               default: ;
            endcase
         end
         if (reg_rd && reg_addr >= ch_base && reg_addr <= (ch_base | CH_MASK)) begin
            case (reg_ofs)
               OFS_SRC:  state_next.rdata = state_reg.src[c];
               OFS_DST:  state_next.rdata = state_reg.dst[c];
               OFS_CNT:  state_next.rdata = {8'h00, state_reg.cnt[c]};
               OFS_CTRL: state_next.rdata = {16'h0000, state_reg.ctrl[c]};
               default:  state_next.rdata = '0;
            endcase
         end

         // Unit progress
         if (unit_done[c] && ch_active[c]) begin
            if (single && !d2m) begin
               // Destination is the strobed device
               state_next.src[c] = stepped(state_reg.src[c], smode, st);
            end else if (single && d2m) begin
               // Source is the strobed device
               state_next.dst[c] = stepped(state_reg.dst[c], dmode, st);
            end else if (sz == DACC_SZ_16B) begin
               // Four longword steps make a unit; source runs ahead regardless of mode
               state_next.src[c] = state_reg.src[c] + STEP_LONG;
               state_next.dst[c] = stepped(state_reg.dst[c], dmode, STEP_LONG);
               state_next.lw_idx[c] = state_reg.lw_idx[c] + 2'b01;
            end else begin
               state_next.src[c] = stepped(state_reg.src[c], smode, st);
               state_next.dst[c] = stepped(state_reg.dst[c], dmode, st);
            end
            lw_done = 1'b1;
            state_next.cnt[c] = state_reg.cnt[c] - CNT_ONE;
            // Zero start wraps through all ones, giving the full 2^24 transfers
            if (state_reg.cnt[c] == CNT_ONE) begin
               state_next.ctrl[c][TEND_BIT] = 1'b1;
            end
         end
      end

      // Standby clears control and longword phase only; addresses and counts persist
      if (standby_entry) begin
         for (int c = 0; c < NUM_CH; c++) begin
            state_next.ctrl[c]   = CTRL_RST;
            state_next.lw_idx[c] = 2'b00;
         end
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // Addresses and counts are don't-care after reset; zeroing them keeps one register process
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign reg_rdata = state_reg.rdata;

   always_comb begin
      for (int c = 0; c < NUM_CH; c++) begin
         ch_enable[c]      = state_reg.ctrl[c][ENABLE_BIT];
         ch_active[c]      = state_reg.ctrl[c][ENABLE_BIT] & ~state_reg.ctrl[c][TEND_BIT];
         ch_single_addr[c] = state_reg.ctrl[c][ADDR_MODE_BIT];
         ch_dev_to_mem[c]  = state_reg.ctrl[c][ACK_DIR_BIT];
         ch_src_used[c]    = ~(state_reg.ctrl[c][ADDR_MODE_BIT] & state_reg.ctrl[c][ACK_DIR_BIT]);
         ch_dst_used[c]    = ~(state_reg.ctrl[c][ADDR_MODE_BIT] & ~state_reg.ctrl[c][ACK_DIR_BIT]);
         ch_src_addr[c*32 +: 32] = state_reg.src[c];
         ch_dst_addr[c*32 +: 32] = state_reg.dst[c];
         ch_lw_phase_last[c] = (state_reg.lw_idx[c] == 2'(LW_STEPS - 3'h1));
      end
   end

endmodule

// File: sim/dacc_far_side.sv
// Far-side model: paces unit steps on each active channel, like a memory or strobed device.
// Assumes the bench gates traffic with go and sets the pace with gap.
`timescale 1ns/1ps

module dacc_far_side (
   input  wire logic       ref_clk,
   input  wire logic       arst_n,
   input  wire logic [1:0] go,
   input  wire logic [1:0] ch_active,
   input  wire logic [3:0] gap,
   output logic      [1:0] unit_done
);
   logic [3:0] wait_cnt [2];

   // Never two pulses back to back, so the end flag can land first
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         unit_done <= '0;
         wait_cnt  <= '{default: '0};
      end else begin
         for (int c = 0; c < 2; c++) begin
            unit_done[c] <= 1'b0;
            if (go[c] && ch_active[c] && !unit_done[c]) begin
               if (wait_cnt[c] >= gap) begin
                  unit_done[c] <= 1'b1;
                  wait_cnt[c]  <= '0;
               end else begin
                  wait_cnt[c] <= wait_cnt[c] + 4'h1;
               end
            end
         end
      end
   end
endmodule

// File: sim/dacc_channel_regs_props.sv
// Checker for the address/count register block, bound to every instance.
// Assumes only the top module's ports are visible.
`timescale 1ns/1ps

module dacc_channel_regs_props
   import dacc_pkg::*;
#(
   parameter int unsigned NUM_CH = 2
) (
   input wire logic                        ref_clk,
   input wire logic                        arst_n,
   input wire logic                        standby_entry,
   input wire logic [dacc_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [dacc_pkg::DATA_W-1:0] reg_wdata,
   input wire logic                        reg_wr,
   input wire logic                        reg_rd,
   input wire logic [dacc_pkg::DATA_W-1:0] reg_rdata,
   input wire logic [NUM_CH-1:0]           ch_enable,
   input wire logic [NUM_CH-1:0]           ch_active,
   input wire logic [NUM_CH-1:0]           ch_single_addr,
   input wire logic [NUM_CH-1:0]           ch_dev_to_mem,
   input wire logic [NUM_CH-1:0]           ch_src_used,
   input wire logic [NUM_CH-1:0]           ch_dst_used
);
   // ----------------------------------------
   // Port relations
   // ----------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   a_cnt_upper_zero: assert property (
      reg_rd && (reg_addr & CH_MASK) == OFS_CNT |=> reg_rdata[31:24] == 8'h00) else $error("count upper bits set");
   a_ctrl_upper_zero: assert property (
      reg_rd && (reg_addr & CH_MASK) == OFS_CTRL |=> reg_rdata[31:16] == 16'h0000) else $error("control upper set");
   a_standby_clears: assert property (
      standby_entry |=> (ch_enable | ch_single_addr | ch_dev_to_mem) == '0) else $error("standby left control");
   a_active_gated: assert property ((ch_active & ~ch_enable) == '0) else $error("active without enable");
   a_src_ignored: assert property (
      (ch_single_addr & ch_dev_to_mem & ch_src_used) == '0) else $error("source used from strobed device");
   a_dst_ignored: assert property (
      (ch_single_addr & ~ch_dev_to_mem & ch_dst_used) == '0) else $error("destination used toward device");
   a_dual_uses_both: assert property (
      (~ch_single_addr & ~(ch_src_used & ch_dst_used)) == '0) else $error("dual mode dropped an address");
   a_mode_bits_wr: assert property (
      reg_wr && reg_addr == OFS_CTRL && !standby_entry |=> ch_single_addr[0] == $past(reg_wdata[3])
      && ch_dev_to_mem[0] == $past(reg_wdata[8])) else $error("mode bits not taken from write");

   c_standby: cover property (standby_entry);
   c_run_end: cover property (ch_active[0] ##1 !ch_active[0]);
   c_single_in: cover property (ch_single_addr[1] && ch_dev_to_mem[1] && ch_active[1]);
endmodule

bind dacc_channel_regs dacc_channel_regs_props #(.NUM_CH(NUM_CH)) u_props (
   .ref_clk, .arst_n, .standby_entry, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
   .ch_enable, .ch_active, .ch_single_addr, .ch_dev_to_mem, .ch_src_used, .ch_dst_used
);

// File: sim/dacc_channel_regs_bench.sv
// Bench: register tasks, stepping runs, standby and count corner cases.
// Assumes the far-side model paces unit steps while go is high.
`timescale 1ns/1ps

module dacc_channel_regs_bench;
   import dacc_pkg::*;
   logic        ref_clk, arst_n, standby_entry, reg_wr, reg_rd;
   logic [7:0]  reg_addr, b;
   logic [31:0] reg_wdata, reg_rdata, rv, cfg;
   logic [1:0]  unit_done, ch_enable, ch_active, ch_single_addr, ch_dev_to_mem, go, sz, md;
   logic [1:0]  ch_src_used, ch_dst_used, ch_lw_phase_last;
   logic [63:0] ch_src_addr, ch_dst_addr;
   logic [3:0]  gap;
   int          mismatches, n_compared, c, st;

   dacc_channel_regs #(.NUM_CH(2)) dut (.ref_clk, .arst_n, .standby_entry, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .unit_done, .ch_enable, .ch_active, .ch_single_addr, .ch_dev_to_mem,
      .ch_src_used, .ch_dst_used, .ch_src_addr, .ch_dst_addr, .ch_lw_phase_last);
   dacc_far_side far (.ref_clk, .arst_n, .go, .ch_active, .gap, .unit_done);

   // ----------------------------------------
   // Access tasks
   // ----------------------------------------
   // Strobes stay up until the next call; reads have no side effect
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      reg_rd    <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic rd(input logic [7:0] a);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      reg_wr   <= 1'b0;
      @(posedge ref_clk);
      #1 rv = reg_rdata;
   endtask
   task automatic idle();
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      n_compared++;
      if (g !== x) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", n, x, g);
      end
   endtask
   task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] x);
      rd(a);
      chk(n, x, rv);
   endtask
   task automatic prog(input logic [7:0] a, input logic [31:0] s, d, n, k);
      wr(a, s);
      wr(a + 8'h4, d);
      wr(a + 8'h8, n);
      wr(a + 8'hc, k);
   endtask
   // Polls the control word until the end flag shows
   task automatic run(input int ch);
      go[ch] <= 1'b1;
      rv = '0;
      for (int k = 0; k < 400 && rv[1] !== 1'b1; k++) rd(8'(ch * 16 + 12));
      go[ch] <= 1'b0;
   endtask
   function automatic int step(input logic [1:0] m, input int s);
      return (m == 2'b01) ? 2 * s : (m == 2'b10) ? -2 * s : 0;
   endfunction
   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Clock, watchdog, tests
   // ----------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      mismatches++;
      tally_and_finish();
   end
   initial begin
      {arst_n, standby_entry, reg_wr, reg_rd, go, reg_addr, reg_wdata, gap} = '0;
      repeat (20) @(posedge ref_clk);
      arst_n <= 1'b1;
      rchk("ctrl0 reset", 8'h0c, 32'h0);
      rchk("ctrl1 reset", 8'h1c, 32'h0);
      wr(8'h10, 32'hdeadbeef);
      rchk("src1 rw", 8'h10, 32'hdeadbeef);
      wr(8'h04, 32'h89abcdef);
      rchk("dst0 rw", 8'h04, 32'h89abcdef);
      wr(8'h08, 32'hab000005);
      rchk("cnt0 upper", 8'h08, 32'h5);
      wr(8'h1c, 32'hffff0002);
      rchk("ctrl1 upper", 8'h1c, 32'h0);
      wr(8'h20, 32'h1);
      rchk("unmapped", 8'h20, 32'h0);
      for (int i = 0; i < 12; i++) begin
         c = i % 2;
         b = 8'(c * 16);
         sz = 2'(i / 4);
         md = 2'(i % 4);
         st = (sz == 2'd0) ? 1 : (sz == 2'd1) ? 2 : 4;
         gap <= 4'(i % 3 * 3);
         cfg = {16'h0, md, ~md, sz, 10'h1};
         prog(b, 32'h1000, 32'h2000, 32'hff000002, cfg);
         run(c);
         chk("end flag", cfg | 32'h2, rv);
         rchk("src step", b, 32'h1000 + 32'(step(~md, st)));
         rchk("dst step", b + 8'h4, 32'h2000 + 32'(step(md, st)));
         rchk("cnt left", b + 8'h8, 32'h0);
         wr(b + 8'hc, cfg & 32'hfffe);
         rchk("flag clear", b + 8'hc, cfg & 32'hfffe);
      end
      gap <= 4'h5;
      prog(8'h0, 32'h100, 32'h300, 32'h8, 32'h6c01);
      run(0);
      rchk("16b src", 8'h0, 32'h120);
      rchk("16b dst", 8'h4, 32'h320);
      rchk("16b cnt", 8'h8, 32'h0);
      chk("16b src port", 32'h120, ch_src_addr[31:0]);
      chk("16b dst port", 32'h320, ch_dst_addr[31:0]);
      chk("16b phase last", 32'h0, {31'h0, ch_lw_phase_last[0]});
      chk("ch0 enable port", 32'h1, {31'h0, ch_enable[0]});
      chk("ch0 active port", 32'h0, {31'h0, ch_active[0]});
      idle();
      standby_entry <= 1'b1;
      idle();
      standby_entry <= 1'b0;
      rchk("standby ctrl", 8'hc, 32'h0);
      rchk("standby src", 8'h0, 32'h120);
      for (int j = 0; j < 2; j++) begin
         prog(8'h10, 32'h500, 32'h600, 32'h3, 32'h5809 | 32'(j << 8));
         run(1);
         rchk("single src", 8'h10, (j == 1) ? 32'h500 : 32'h50c);
         rchk("single dst", 8'h14, (j == 1) ? 32'h60c : 32'h600);
         chk("single src port", (j == 1) ? 32'h500 : 32'h50c, ch_src_addr[63:32]);
         chk("single dst port", (j == 1) ? 32'h60c : 32'h600, ch_dst_addr[63:32]);
         chk("single mode port", 32'h1, {31'h0, ch_single_addr[1]});
         chk("direction port", 32'(j), {31'h0, ch_dev_to_mem[1]});
         chk("src used port", 32'(1 - j), {31'h0, ch_src_used[1]});
         chk("dst used port", 32'(j), {31'h0, ch_dst_used[1]});
      end
      prog(8'h0, 32'h10, 32'h20, 32'h0, 32'h1001);
      go[0] <= 1'b1;
      rv = '0;
      for (int k = 0; k < 50 && rv === 32'h0; k++) rd(8'h8);
      go[0] <= 1'b0;
      chk("max count", 32'hffffff, rv);
      rchk("no end", 8'hc, 32'h1001);
      wr(8'hc, 32'h0);
      idle();
      tally_and_finish();
   end
endmodule
